// ---- hdl/output_buffer_status.sv ----
module output_buffer_status #(
	parameter int DEPTH = output_buffer_pkg::CAPACITY
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       sample_push,
	output      logic       push_dropped,
	output_buffer_if.device bus
);
	initial begin
		if (DEPTH < 1 || DEPTH > 63) begin
			$error("DEPTH must fit a six-bit count");
		end
	end

	localparam logic [5:0] DEPTH_C = 6'(DEPTH);

	logic [5:0] count_reg, count_next;     // Stored triplets
	logic       ovf_reg, ovf_next;         // Overflow flag
	logic [2:0] byte_reg, byte_next;       // Bytes of current triplet read
	logic [7:0] data_reg, data_next;       // Read answer
	logic       valid_reg, valid_next;     // Read answer strobe
	logic       interrupt_pin_one_reg, interrupt_pin_one_next;       // Interrupt pin one
	logic       interrupt_pin_two_reg, interrupt_pin_two_next;       // Interrupt pin two
	logic       drop_reg, drop_next;       // Dropped push pulse
	logic       enabled;                   // Buffer mode nonzero
	logic       wmrk;                      // Live watermark flag
	logic       data_read;                 // Byte read of sample data
	logic       triplet_done;              // Last byte of a triplet read
	logic [2:0] bytes_per;                 // Bytes per triplet

	assign push_dropped = drop_reg;

	// Status flags and counters, next values
	always_comb begin
		enabled   = bus.buffer_mode != output_buffer_pkg::MODE_OFF;
		bytes_per = bus.fast_read ? output_buffer_pkg::BYTES_FAST
		                          : output_buffer_pkg::BYTES_NORMAL;
		data_read = bus.rd_strobe && enabled && count_reg != 6'h00
		            && bus.rd_addr >= output_buffer_pkg::DATA_ADDR;
		triplet_done = data_read && (byte_reg + 3'h1 == bytes_per);
		count_next = count_reg;
		ovf_next   = ovf_reg;
		byte_next  = byte_reg;
		drop_next  = 1'b0;
		if (!enabled || bus.flush) begin
			// Empty and drop flags
			count_next = 6'h00;
			ovf_next   = 1'b0;
			byte_next  = 3'h0;
		end else begin
			if (data_read) begin
				// Advance within triplet
				byte_next = triplet_done ? 3'h0 : byte_reg + 3'h1;
				ovf_next  = 1'b0;
			end
			if (sample_push && count_reg == DEPTH_C) begin
				// Full: count holds, overflow set wins over clear
				ovf_next  = 1'b1;
				drop_next = 1'b1;
				if (triplet_done) begin
					count_next = count_reg;        // One out, push still flagged dropped
				end
			end else if (sample_push && !triplet_done) begin
				count_next = count_reg + 6'h01;
			end else if (!sample_push && triplet_done) begin
				count_next = count_reg - 6'h01;
			end
		end
		// Watermark from count and level
		wmrk = enabled && count_reg >= bus.wmrk_level;
		// Read answer
		data_next  = 8'h00;
		valid_next = bus.rd_strobe;
		if (bus.rd_strobe && bus.rd_addr == output_buffer_pkg::STATUS_ADDR)
		begin
			if (enabled) begin
				// Status byte layout
				data_next[output_buffer_pkg::WMRK_BIT] = wmrk;
				data_next[output_buffer_pkg::OVF_BIT]  = ovf_reg;
				data_next[output_buffer_pkg::CNT_MSB:0] = count_reg;
			end else begin
				data_next = output_buffer_pkg::STATUS_RESET;
			end
		end
		// Interrupt routing
		interrupt_pin_one_next = bus.int_enable && wmrk
		            && bus.int_route == output_buffer_pkg::ROUTE_PIN_ONE;
		interrupt_pin_two_next = bus.int_enable && wmrk
		            && bus.int_route != output_buffer_pkg::ROUTE_PIN_ONE;
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 6'h00;
			ovf_reg   <= 1'b0;
			byte_reg  <= 3'h0;
			data_reg  <= output_buffer_pkg::STATUS_RESET;
			valid_reg <= 1'b0;
			interrupt_pin_one_reg  <= 1'b0;
			interrupt_pin_two_reg  <= 1'b0;
			drop_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			ovf_reg   <= ovf_next;
			byte_reg  <= byte_next;
			data_reg  <= data_next;
			valid_reg <= valid_next;
			interrupt_pin_one_reg  <= interrupt_pin_one_next;
			interrupt_pin_two_reg  <= interrupt_pin_two_next;
			drop_reg  <= drop_next;
		end
	end

	assign bus.rd_data           = data_reg;
	assign bus.rd_valid          = valid_reg;
	assign bus.interrupt_pin_one = interrupt_pin_one_reg;
	assign bus.interrupt_pin_two = interrupt_pin_two_reg;
endmodule

// ---- inc/output_buffer_pkg.sv ----
package output_buffer_pkg;
	// Register offset of the status byte
	localparam logic [7:0] STATUS_ADDR = 8'h0b;
	// First buffered sample data register
	localparam logic [7:0] DATA_ADDR   = 8'h0c;
	// Status byte field positions
	localparam int WMRK_BIT  = 7;
	localparam int OVF_BIT   = 6;
	localparam int CNT_MSB   = 5;
	// Reset value of the status byte
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Buffer capacity in triplets
	localparam int CAPACITY  = 32;
	// Bytes per triplet in normal and fast-read mode
	localparam logic [2:0] BYTES_NORMAL = 3'h6;
	localparam logic [2:0] BYTES_FAST   = 3'h3;
	// Disabled buffer mode code
	localparam logic [1:0] MODE_OFF = 2'h0;
	// Interrupt routing choices
	localparam logic ROUTE_PIN_ONE = 1'b0;
	// Host walker states
	typedef enum logic [1:0] {
		H_IDLE,
		H_STATUS,
		H_DRAIN
	} host_state_t;
endpackage

// ---- inc/output_buffer_if.sv ----
interface output_buffer_if;
	logic [7:0] rd_addr;      // Register address of a byte read
	logic       rd_strobe;    // One-cycle byte read request
	logic [7:0] rd_data;      // Byte returned one cycle later
	logic       rd_valid;     // Marks rd_data
	logic [1:0] buffer_mode;  // Buffer mode, zero disables
	logic       flush;        // One-cycle flush request
	logic [5:0] wmrk_level;   // Watermark level
	logic       fast_read;    // One byte per axis
	logic       int_enable;   // Watermark interrupt enable
	logic       int_route;    // Pin select for the watermark
	logic       interrupt_pin_one;
	logic       interrupt_pin_two;
	modport device (
		input  rd_addr, rd_strobe, buffer_mode, flush, wmrk_level,
		input  fast_read, int_enable, int_route,
		output rd_data, rd_valid, interrupt_pin_one, interrupt_pin_two
	);
	modport host (
		output rd_addr, rd_strobe, buffer_mode, flush, wmrk_level,
		output fast_read, int_enable, int_route,
		input  rd_data, rd_valid, interrupt_pin_one, interrupt_pin_two
	);
endinterface

// ---- hdl/output_buffer_host.sv ----
module output_buffer_host (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] cfg_mode,
	input  wire logic [5:0] cfg_level,
	input  wire logic       cfg_fast,
	input  wire logic       cfg_int_en,
	input  wire logic       cfg_route,
	input  wire logic       flush_req,
	output      logic [7:0] status_byte,
	output      logic       status_valid,
	output      logic       busy,
	output_buffer_if.host   bus
);
	logic [7:0] addr_reg, addr_next;        // Read address
	logic       strobe_reg, strobe_next;    // Read request
	logic       flush_reg, flush_next;      // Flush pulse
	logic [8:0] left_reg, left_next;        // Data bytes left in burst
	logic [7:0] stat_reg, stat_next;        // Last status byte
	logic       sv_reg, sv_next;            // Status valid pulse
	output_buffer_pkg::host_state_t st_reg, st_next;
	logic       irq;                        // Either interrupt pin
	logic [2:0] bpt;                        // Bytes per triplet

	// Burst walker: status byte then drain, next values
	always_comb begin
		irq = bus.interrupt_pin_one || bus.interrupt_pin_two;
		bpt = cfg_fast ? output_buffer_pkg::BYTES_FAST
		               : output_buffer_pkg::BYTES_NORMAL;
		st_next = st_reg;
		addr_next = addr_reg;
		strobe_next = 1'b0;
		flush_next = flush_req;
		left_next = left_reg;
		stat_next = stat_reg;
		sv_next = 1'b0;
		unique case (st_reg)
			output_buffer_pkg::H_IDLE: begin
				if (irq && !flush_req) begin
					// Start burst at status byte
					addr_next = output_buffer_pkg::STATUS_ADDR;
					strobe_next = 1'b1;
					st_next = output_buffer_pkg::H_STATUS;
				end
			end
			output_buffer_pkg::H_STATUS: begin
				if (bus.rd_valid) begin
					stat_next = bus.rd_data;
					sv_next = 1'b1;
					// Drain all counted triplets
					left_next = 9'(bus.rd_data[output_buffer_pkg::CNT_MSB:0])
					            * 9'(bpt);
					st_next = output_buffer_pkg::H_DRAIN;
				end
			end
			output_buffer_pkg::H_DRAIN: begin
				if (left_reg == 9'h000) begin
					// Wait out the last answer so the lagging pin
					// cannot restart a burst on an emptied buffer
					if (!strobe_reg && !bus.rd_valid) begin
						st_next = output_buffer_pkg::H_IDLE;
					end
				end else if (!strobe_reg) begin
					addr_next = output_buffer_pkg::DATA_ADDR;
					strobe_next = 1'b1;
					left_next = left_reg - 9'h001;
				end
			end
			default: st_next = output_buffer_pkg::H_IDLE;
		endcase
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= output_buffer_pkg::H_IDLE;
			addr_reg <= 8'h00;
			strobe_reg <= 1'b0;
			flush_reg <= 1'b0;
			left_reg <= 9'h000;
			stat_reg <= 8'h00;
			sv_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			addr_reg <= addr_next;
			strobe_reg <= strobe_next;
			flush_reg <= flush_next;
			left_reg <= left_next;
			stat_reg <= stat_next;
			sv_reg <= sv_next;
		end
	end

	assign status_byte = stat_reg;
	assign status_valid = sv_reg;
	assign busy = st_reg != output_buffer_pkg::H_IDLE;
	assign bus.rd_addr = addr_reg;
	assign bus.rd_strobe = strobe_reg;
	assign bus.flush = flush_reg;
	assign bus.buffer_mode = cfg_mode;
	assign bus.wmrk_level = cfg_level;
	assign bus.fast_read = cfg_fast;
	assign bus.int_enable = cfg_int_en;
	assign bus.int_route = cfg_route;
endmodule

// ---- testbench/output_buffer_assertions.sv ----
module output_buffer_assertions (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] rd_addr,
	input wire logic       rd_strobe,
	input wire logic [7:0] rd_data,
	input wire logic       rd_valid,
	input wire logic [1:0] buffer_mode,
	input wire logic [5:0] wmrk_level,
	input wire logic       int_enable,
	input wire logic       int_route,
	input wire logic       interrupt_pin_one,
	input wire logic       interrupt_pin_two
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Status byte read request
	logic st_rd;
	assign st_rd = rd_strobe && rd_addr == output_buffer_pkg::STATUS_ADDR;
	a_valid_follows: assert property (rd_strobe |=> rd_valid)
		else $error("read answer missing");
	a_no_stray: assert property (rd_valid |-> $past(rd_strobe))
		else $error("answer without request");
	a_off_zero: assert property (st_rd && buffer_mode == 2'h0 |=>
		rd_data == 8'h00) else $error("status not zero while off");
	a_wmrk_level: assert property (st_rd && buffer_mode != 2'h0 |=>
		rd_data[7] == (rd_data[5:0] >= $past(wmrk_level)))
		else $error("watermark flag disagrees with count");
	a_count_range: assert property (st_rd |=> rd_data[5:0] <= 6'h20)
		else $error("count above capacity");
	a_pin_one_off: assert property (int_route && $past(int_route) |->
		!interrupt_pin_one) else $error("pin one driven when routed away");
	a_pin_two_off: assert property (!int_route && !$past(int_route) |->
		!interrupt_pin_two) else $error("pin two driven when routed away");
	a_int_gated: assert property (!int_enable && !$past(int_enable) |->
		!interrupt_pin_one && !interrupt_pin_two)
		else $error("interrupt while disabled");
	// Main scenarios
	c_wmrk: cover property (st_rd ##1 rd_data[7]);
	c_pin_two: cover property (interrupt_pin_two);
	c_pin_one: cover property (interrupt_pin_one);
endmodule

// ---- testbench/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       push = 1'b0;  // One triplet stored
	logic       dropped;      // Push refused while full
	logic [1:0] mode = 2'h0;
	logic [5:0] level = 6'h00;
	logic       fast = 1'b0;
	logic       int_en = 1'b0;
	logic       route = 1'b0;
	logic       flush_req = 1'b0;
	logic [7:0] status_byte;
	logic       status_valid;
	logic       busy;
	logic [7:0] b;            // Last status seen by the host
	int         errors = 0;
	int         compares = 0;
	output_buffer_if ob();
	output_buffer_status output_buffer_status_i (.clk(clk), .rst_n(rst_n),
		.sample_push(push), .push_dropped(dropped), .bus(ob));
	output_buffer_host output_buffer_host_i (.clk(clk), .rst_n(rst_n),
		.cfg_mode(mode), .cfg_level(level), .cfg_fast(fast),
		.cfg_int_en(int_en), .cfg_route(route), .flush_req(flush_req),
		.status_byte(status_byte), .status_valid(status_valid),
		.busy(busy), .bus(ob));
	output_buffer_assertions output_buffer_assertions_i (.clk(clk),
		.rst_n(rst_n), .rd_addr(ob.rd_addr), .rd_strobe(ob.rd_strobe),
		.rd_data(ob.rd_data), .rd_valid(ob.rd_valid),
		.buffer_mode(ob.buffer_mode), .wmrk_level(ob.wmrk_level),
		.int_enable(ob.int_enable), .int_route(ob.int_route),
		.interrupt_pin_one(ob.interrupt_pin_one),
		.interrupt_pin_two(ob.interrupt_pin_two));
	// 250 MHz clock
	always #2 clk = ~clk;
	// Compare one byte
	task check8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Store n triplets, one every other cycle
	task push_n(input int n);
		repeat (n) begin
			@(negedge clk) push = 1'b1;
			@(negedge clk) push = 1'b0;
		end
	endtask
	// Wait for the host's status read, then for its drain to end
	task wait_status;
		int n;
		n = 0;
		while (status_valid !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		b = status_byte;
		if (n >= 300) begin
			errors++;
			end_sim;
		end
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000) begin
			errors++;
			end_sim;
		end
	endtask
	// Watermark reached drives pin one, drain clears it
	task t_wmrk;
		mode = 2'h1;
		level = 6'h04;
		int_en = 1'b1;
		push_n(3);
		repeat (3) @(negedge clk);
		check8({7'h00, ob.interrupt_pin_one}, 8'h00);
		push_n(1);
		wait_status;
		check8(b, 8'h84);
		repeat (2) @(negedge clk);
		check8({7'h00, ob.interrupt_pin_one}, 8'h00);
	endtask
	// Watermark routed to pin two
	task t_route;
		route = 1'b1;
		push_n(4);
		repeat (2) @(negedge clk);
		check8({6'h00, ob.interrupt_pin_two, ob.interrupt_pin_one}, 8'h02);
		wait_status;
		check8(b, 8'h84);
	endtask
	// Overflow at capacity, then flush empties and clears
	task t_ovf;
		int_en = 1'b0;
		push_n(33);
		check8({7'h00, dropped}, 8'h01);
		@(negedge clk) flush_req = 1'b1;
		@(negedge clk) flush_req = 1'b0;
		level = 6'h01;
		int_en = 1'b1;
		push_n(1);
		wait_status;
		check8(b, 8'h81);
	endtask
	// Disable discards contents, fast read drain
	task t_disable;
		int_en = 1'b0;
		fast = 1'b1;
		push_n(5);
		@(negedge clk) mode = 2'h0;
		repeat (3) @(negedge clk);
		mode = 2'h1;
		int_en = 1'b1;
		push_n(1);
		wait_status;
		check8(b, 8'h81);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		check8(status_byte, 8'h00);
		t_wmrk;
		t_route;
		t_ovf;
		t_disable;
		end_sim;
	end
	// Watchdog against a hang
	initial begin
		#100us;
		errors++;
		end_sim;
	end
endmodule
